// File: hdl/itp_pkg.sv
/*
 * itp_pkg: constants and carrier types for the two-wire target port.
 * assumes: a single 25 MHz reference clock samples the bus pins.
 */
package itp_pkg;
    // ****************************************************************
    // address and timing
    // ****************************************************************
    localparam logic [4:0] ITP_ADDR_HI = 5'h0D; // fixed upper bits 01101
    localparam logic [1:0] ITP_STRAP_GND = 2'h0;
    localparam logic [1:0] ITP_STRAP_VCC = 2'h3;
    localparam logic [1:0] ITP_STRAP_SCL = 2'h1;
    localparam logic [1:0] ITP_STRAP_SDA = 2'h2;
    localparam int ITP_CLK_MHZ = 25;
    localparam int ITP_SCL_MAX_KHZ = 1000;
    localparam int ITP_SCL_MIN_CYC = (ITP_CLK_MHZ * 1000) / ITP_SCL_MAX_KHZ;
    localparam logic [3:0] ITP_BIT_LAST = 4'h7; // count before last data rise
    localparam logic [3:0] ITP_BIT_ACK = 4'h8;  // count before the ninth rise
    localparam logic [3:0] ITP_BIT_END = 4'h9;  // count while ninth clock stands
    localparam logic [7:0] ITP_PTR_RST = 8'h00;
    localparam int ITP_FIFO_DEPTH = 16;
    localparam int ITP_BYTE_W = 8;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [5:0] {
        ITP_IDLE = 6'h01,
        ITP_ADDR = 6'h02,
        ITP_AACK = 6'h04,
        ITP_WRX  = 6'h08,
        ITP_WACK = 6'h10,
        ITP_RTX  = 6'h20
    } itp_state_e;

    // register write carried to the register bank
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } itp_wr_s;
endpackage : itp_pkg

// File: hdl/itp_fifo.sv
/*
 * itp_fifo: small synchronous valid/ready FIFO.
 * assumes: one clock, asynchronous active-low reset.
 */
module itp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    wire push = i_in_valid && o_in_ready;
    wire pop = o_out_valid && i_out_ready;

    // honest flags from pointer compare
    assign o_in_ready = (wr_q - rd_q) != (AW + 1)'(DEPTH);
    assign o_out_valid = wr_q != rd_q;
    assign o_out_data = mem_q[rd_q[AW-1:0]];

    // storage
    always_ff @(posedge i_ref_clk) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= i_in_data;
        end
    end

    // pointers
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_q + (AW + 1)'(push);
            rd_q <= rd_q + (AW + 1)'(pop);
        end
    end
endmodule : itp_fifo

// File: hdl/itp_target.sv
/*
 * itp_target: two-wire bus target port with register pointer.
 * assumes: scl/sda/strap are asynchronous pins, external pull-ups,
 * a register bank that takes writes and returns read data same cycle.
 */
// Function
// RULE_01: answer to address 01101 plus strap bits
// RULE_02: direction 0 writes, 1 reads
// RULE_03: strap wiring selects low address bits
// RULE_04: host clock no faster than 1MHz
// RULE_05: data only pulled low, clock input
// RULE_06: sample data while clock high
// RULE_07: host keeps data high when idle
// RULE_08: start begins address compare
// RULE_09: address byte sent msb first
// RULE_10: pull data low in ack if matched
// RULE_11: host stops on missing acknowledge
// RULE_12: first write byte loads register pointer
// RULE_13: acknowledge and store each data byte; the code naks and drops a data byte while the FIFO is full
// RULE_14: stop returns target to idle
// RULE_15: pointer increments on each data acknowledge
// RULE_16: repeated start read returns pointed register
// RULE_17: read msb first, host naks last
module itp_target (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe,
    input wire logic i_strap_gnd,
    input wire logic i_strap_vcc,
    input wire logic i_strap_scl,
    output logic o_wr_valid,
    input wire logic i_wr_ready,
    output itp_pkg::itp_wr_s o_wr,
    output logic [7:0] o_rd_addr,
    input wire logic [7:0] i_rd_data,
    output logic o_busy
);
    import itp_pkg::*;

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [1:0] scl_m_q, sda_m_q;
    logic scl_q, sda_q, scl_p_q, sda_p_q;
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            scl_m_q <= 2'h3;
            sda_m_q <= 2'h3;
        end else begin
            scl_m_q <= {scl_m_q[0], i_scl};
            sda_m_q <= {sda_m_q[0], i_sda};
        end
    end
    // third stage plus one more for edge detection
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_q <= scl_m_q[1];
            sda_q <= sda_m_q[1];
            scl_p_q <= scl_q;
            sda_p_q <= sda_q;
        end
    end

    // bus events
    wire scl_rise = scl_q && !scl_p_q; // see RULE_06
    wire scl_fall = !scl_q && scl_p_q;
    wire start_ev = scl_q && scl_p_q && sda_p_q && !sda_q; // see RULE_08
    wire stop_ev = scl_q && scl_p_q && !sda_p_q && sda_q; // see RULE_14

    // ****************************************************************
    // strap capture after reset
    // ****************************************************************
    logic [1:0] strap_q;
    logic strap_done_q;
    wire [1:0] strap_d = i_strap_gnd ? ITP_STRAP_GND :
                         i_strap_vcc ? ITP_STRAP_VCC :
                         i_strap_scl ? ITP_STRAP_SCL : ITP_STRAP_SDA;
    // latch once after release
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            strap_q <= ITP_STRAP_GND;
            strap_done_q <= 1'b0;
        end else if (!strap_done_q) begin
            strap_q <= strap_d; // see RULE_03
            strap_done_q <= 1'b1;
        end
    end

    // ****************************************************************
    // protocol engine
    // ****************************************************************
    itp_state_e st_q, st_d;
    logic [3:0] bit_q;
    logic [7:0] sh_q;
    logic [7:0] ptr_q;
    logic first_q; // next write byte is the register address
    logic rd_q;    // current transfer is a read
    logic ack_q;   // we drive the ack this ninth bit
    logic drive_q;
    logic fifo_ready;

    // byte framing: rises 0..7 carry data, the ninth rise is the ack
    wire [7:0] sh_next = {sh_q[6:0], sda_q};
    wire byte_done = scl_rise && bit_q == ITP_BIT_LAST;
    wire ack_rise = scl_rise && bit_q == ITP_BIT_ACK;
    wire byte_end = scl_fall && bit_q == ITP_BIT_END;
    wire host_nak = st_q == ITP_RTX && ack_rise && sda_q; // see RULE_17
    wire addr_hit = sh_next[7:1] == {ITP_ADDR_HI, strap_q}; // see RULE_01
    wire data_push = st_q == ITP_WRX && byte_done && !first_q;

    // next state
    always_comb begin
        st_d = st_q;
        case (st_q)
            ITP_IDLE: st_d = ITP_IDLE;
            ITP_ADDR: if (byte_done) st_d = addr_hit ? ITP_AACK : ITP_IDLE;
            ITP_AACK: if (byte_end) st_d = rd_q ? ITP_RTX : ITP_WRX;
            ITP_WRX: if (byte_done) st_d = ITP_WACK;
            ITP_WACK: if (byte_end) st_d = ack_q ? ITP_WRX : ITP_IDLE;
            ITP_RTX: if (host_nak) st_d = ITP_IDLE; // see RULE_17
            default: st_d = ITP_IDLE;
        endcase
        if (start_ev) st_d = ITP_ADDR; // see RULE_08
        if (stop_ev) st_d = ITP_IDLE; // see RULE_14
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_q <= ITP_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // bit counter and shifter, sampled on scl rise
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            bit_q <= 4'h0;
            sh_q <= 8'h00;
        end else if (start_ev || byte_end) begin
            bit_q <= 4'h0;
        end else if (scl_rise) begin
            bit_q <= bit_q + 4'h1;
            if (bit_q <= ITP_BIT_LAST) begin
                sh_q <= sh_next; // msb first, see RULE_09
            end
        end
    end

    // direction, pointer and first-byte flag
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rd_q <= 1'b0;
            first_q <= 1'b1;
            ptr_q <= ITP_PTR_RST;
        end else begin
            if (st_q == ITP_ADDR && byte_done) begin
                rd_q <= sh_next[0]; // see RULE_02
                first_q <= 1'b1;
            end
            if (st_q == ITP_WRX && byte_done && first_q) begin
                ptr_q <= sh_next; // see RULE_12
                first_q <= 1'b0;
            end
            if (data_push && fifo_ready) begin
                ptr_q <= ptr_q + 8'h01; // see RULE_15
            end
            if (st_q == ITP_RTX && ack_rise) begin
                ptr_q <= ptr_q + 8'h01; // next read byte
            end
        end
    end

    // ack decision: address match, and room for data
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ack_q <= 1'b0;
        end else if (st_q == ITP_ADDR && byte_done) begin
            ack_q <= addr_hit; // see RULE_10
        end else if (st_q == ITP_WRX && byte_done) begin
            ack_q <= first_q || fifo_ready; // see RULE_13
        end
    end

    // read data shifter: load byte before first bit, then shift
    logic [7:0] tx_q;
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tx_q <= 8'hFF;
        end else if (st_q == ITP_AACK || (st_q == ITP_RTX && byte_end)) begin
            tx_q <= i_rd_data; // see RULE_16
        end else if (st_q == ITP_RTX && scl_fall && bit_q != 4'h0 &&
                     bit_q <= ITP_BIT_LAST) begin
            tx_q <= {tx_q[6:0], 1'b1}; // see RULE_17
        end
    end

    // drive low only: ack or a zero read bit, switched while scl low
    wire ack_win = bit_q == ITP_BIT_END || (bit_q == ITP_BIT_ACK && !scl_p_q);
    wire ack_drv = (st_q == ITP_AACK || st_q == ITP_WACK) && ack_q && ack_win;
    wire rd_win = bit_q <= ITP_BIT_LAST || (bit_q == ITP_BIT_ACK && scl_p_q);
    wire rd_drv = st_q == ITP_RTX && !tx_q[7] && rd_win; // host owns ack
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            drive_q <= 1'b0;
        end else if (start_ev || stop_ev) begin
            drive_q <= 1'b0;
        end else begin
            drive_q <= ack_drv || rd_drv; // see RULE_05, RULE_10
        end
    end

    // ****************************************************************
    // write data buffer and outputs
    // ****************************************************************
    itp_wr_s push_w;
    assign push_w = '{addr: ptr_q, data: sh_next};
    logic out_valid;
    itp_wr_s out_w;
    itp_fifo #(.WIDTH(2 * ITP_BYTE_W), .DEPTH(ITP_FIFO_DEPTH)) u_fifo (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_in_valid(data_push),
        .o_in_ready(fifo_ready),
        .i_in_data(push_w),
        .o_out_valid(out_valid),
        .i_out_ready(!o_wr_valid || i_wr_ready),
        .o_out_data(out_w)
    );

    // registered outputs
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_wr_valid <= 1'b0;
            o_wr <= '0;
            o_rd_addr <= ITP_PTR_RST;
            o_sda_oe <= 1'b0;
            o_busy <= 1'b0;
        end else begin
            if (!o_wr_valid || i_wr_ready) begin
                o_wr_valid <= out_valid;
                o_wr <= out_w;
            end
            o_rd_addr <= ptr_q;
            o_sda_oe <= drive_q; // see RULE_05
            o_busy <= st_q != ITP_IDLE;
        end
    end
    assign o_sda_out = 1'b0;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);

    stop_idle_a: assert property (stop_ev |=> st_q == ITP_IDLE) // see RULE_14
        else $error("stop did not idle");
    start_addr_a: assert property (start_ev |=> st_q == ITP_ADDR) // see RULE_08
        else $error("start did not begin address");
    miss_noack_a: assert property ( // see RULE_01
        st_q == ITP_ADDR && byte_done && !addr_hit && !stop_ev && !start_ev
        |=> st_q == ITP_IDLE) else $error("foreign address taken");
    hit_ack_a: assert property ( // see RULE_10
        st_q == ITP_ADDR && byte_done && addr_hit && !stop_ev
        |=> st_q == ITP_AACK && ack_q) else $error("own address not acked");
    ptr_load_a: assert property ( // see RULE_12
        st_q == ITP_WRX && byte_done && first_q && !stop_ev
        |=> ptr_q == $past(sh_next)) else $error("pointer not loaded");
    ptr_inc_a: assert property ( // see RULE_15
        data_push && fifo_ready && !stop_ev
        |=> ptr_q == $past(ptr_q) + 8'h01) else $error("pointer not bumped");
    dir_bit_a: assert property ( // see RULE_02
        st_q == ITP_ADDR && byte_done |=> rd_q == $past(sh_next[0]))
        else $error("direction bit lost");
    oe_idle_a: assert property ( // see RULE_05
        st_q == ITP_IDLE && $past(st_q) == ITP_IDLE |=> !o_sda_oe)
        else $error("data driven while idle");
    sample_high_a: assert property ( // see RULE_06
        $changed(sh_q) |-> $rose(scl_p_q)) else $error("sampled off clock rise");
    oe_low_phase_a: assert property ( // see RULE_06
        $changed(drive_q) |-> !scl_p_q) else $error("data moved in clock high");
    read_nak_a: assert property ( // see RULE_17
        host_nak && !start_ev |=> st_q == ITP_IDLE)
        else $error("read went on after nak");

    write_c: cover property (data_push && fifo_ready);
    nak_c: cover property (st_q == ITP_WACK && !ack_q);
    read_c: cover property (st_q == ITP_RTX);
    full_c: cover property (!fifo_ready);
endmodule : itp_target

// File: tb/itp_host_model.sv
/*
 * itp_host_model: behavioural bus controller that drives the target port.
 * assumes: the bench resolves the open-drain data wire with a pull-up.
 */
module itp_host_model (
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_low
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************************************
    // bus phases, timed apart from the reference clock
    // ****************************************************************
    localparam real QTR = 252.5; // 1010 ns bit time
    int glitch_cnt = 0;
    // idle: clock stands high, data released
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    // one pulse; data moves only while the clock is low
    task automatic bit_cycle(input logic b, output logic r);
        logic r2;
        o_sda_low = ~b;
        #(QTR) o_scl = 1'b1;
        #(QTR / 2) r = i_sda;
        #(QTR) r2 = i_sda;
        if (r2 !== r) glitch_cnt++;
        #(QTR / 2) o_scl = 1'b0;
        #(QTR);
    endtask : bit_cycle
    // start or repeated start: data falls while the clock is high
    task automatic start_cond();
        o_sda_low = 1'b0;
        #(QTR) o_scl = 1'b1;
        #(QTR) o_sda_low = 1'b1;
        #(QTR) o_scl = 1'b0;
        #(QTR);
    endtask : start_cond
    // stop: data rises while the clock is high
    task automatic stop_cond();
        o_sda_low = 1'b1;
        #(QTR) o_scl = 1'b1;
        #(QTR) o_sda_low = 1'b0;
        #(QTR);
    endtask : stop_cond
    // byte out msb first, then data released for the acknowledge
    task automatic put_byte(input logic [7:0] b, output logic acked);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(b[i], r);
        end
        bit_cycle(1'b1, r);
        acked = ~r;
    endtask : put_byte
    // byte in msb first; the last one is answered with no acknowledge
    task automatic get_byte(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b1, b[i]);
        end
        bit_cycle(last, r);
    endtask : get_byte
endmodule : itp_host_model

// File: tb/tb.sv
/*
 * tb: self-checking bench for the two-wire target port.
 * assumes: host model on the wire, a 256-byte bank behind the port.
 */
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import itp_pkg::*;
    // ****************************************************************
    // wiring, bank and helpers
    // ****************************************************************
    logic clk = 1'b0, rst_b = 1'b0, st_gnd = 1'b0, st_vcc = 1'b0;
    logic st_scl = 1'b0, wr_ready = 1'b0, ack, sda_oe, sda_out, wr_valid;
    logic scl, host_low, sda, busy;
    logic [1:0] strap_v;
    logic [7:0] rd_addr, p, bank [256], exp_mem [256];
    logic [15:0] rnd_q = 16'h62BC;
    logic [15:0] exp_q [$];
    itp_wr_s wr;
    int errors = 0, check_count = 0, ready_mode = 1, n;
    localparam logic [1:0] STRAP_TBL [4] = '{2'h0, 2'h3, 2'h1, 2'h2};
    // pull-up wired-and of both parties
    assign sda = ~host_low & ~(sda_oe & ~sda_out);
    itp_target u_dut (.i_ref_clk(clk), .i_rst_b(rst_b), .i_scl(scl),
        .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
        .i_strap_gnd(st_gnd), .i_strap_vcc(st_vcc), .i_strap_scl(st_scl),
        .o_wr_valid(wr_valid), .i_wr_ready(wr_ready), .o_wr(wr),
        .o_rd_addr(rd_addr), .i_rd_data(bank[rd_addr]), .o_busy(busy));
    itp_host_model u_host (.i_sda(sda), .o_scl(scl), .o_sda_low(host_low));
    // 25 MHz reference clock
    initial begin
        forever #20 clk = ~clk;
    end
    function automatic logic [7:0] rnd8();
        rnd_q = {rnd_q[14:0], rnd_q[15] ^ rnd_q[13] ^ rnd_q[12] ^ rnd_q[10]};
        return rnd_q[7:0];
    endfunction : rnd8
    function automatic logic [7:0] addr_byte(input logic [1:0] st,
                                             input logic rw);
        return {5'h0D, st, rw};
    endfunction : addr_byte
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_val
    task automatic chk_flag(input logic got, input logic exp);
        chk_val({15'h0000, got}, {15'h0000, exp});
    endtask : chk_flag
    task automatic report_and_stop();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop
    // bank back-pressure: stalled, random or always ready
    always @(negedge clk) begin
        wr_ready <= ready_mode == 2 || (ready_mode == 1 && rnd8() > 8'h7F);
    end
    // bank takes writes and checks them against bus order
    always @(posedge clk) begin
        if (sda_oe === 1'b1) chk_flag(sda_out, 1'b0);
        if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
            bank[wr.addr] <= wr.data;
            chk_flag(exp_q.size() != 0, 1'b1);
            if (exp_q.size() != 0) chk_val(wr, exp_q.pop_front());
        end
    end
    // one data byte; expectation dropped again if refused
    task automatic send_data(input logic [7:0] a, output logic acked);
        logic [7:0] d;
        d = rnd8();
        exp_q.push_back({a, d});
        u_host.put_byte(d, acked);
        if (acked) exp_mem[a] = d;
        else void'(exp_q.pop_back());
    endtask : send_data
    task automatic open_write(input logic [7:0] ptr);
        u_host.start_cond();
        u_host.put_byte(addr_byte(strap_v, 1'b0), ack);
        chk_flag(ack, 1'b1);
        chk_flag(busy, 1'b1);
        u_host.put_byte(ptr, ack);
        chk_flag(ack, 1'b1);
    endtask : open_write
    task automatic rd_burst(input logic [7:0] ptr, input int cnt,
                            input logic set_ptr);
        logic [7:0] b;
        if (set_ptr) begin
            open_write(ptr);
        end
        u_host.start_cond();
        u_host.put_byte(addr_byte(strap_v, 1'b1), ack);
        chk_flag(ack, 1'b1);
        for (int i = 0; i < cnt; i++) begin
            u_host.get_byte(i == cnt - 1, b);
            chk_val({8'h00, b}, {8'h00, exp_mem[ptr + 8'(i)]});
        end
        u_host.stop_cond();
        repeat (3) @(negedge clk);
        chk_flag(busy, 1'b0);
    endtask : rd_burst
    task automatic wait_drain();
        for (int i = 0; i < 300 && exp_q.size() != 0; i++) @(negedge clk);
        if (exp_q.size() != 0) begin
            errors++;
            report_and_stop();
        end
    endtask : wait_drain
    // hang guard
    initial begin
        #3000000;
        errors++;
        report_and_stop();
    end
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        for (int k = 0; k < 256; k++) begin
            bank[k] = rnd8();
            exp_mem[k] = bank[k];
        end
        for (int s = 0; s < 4; s++) begin
            @(negedge clk);
            rst_b = 1'b0;
            st_gnd = (s == 0);
            st_vcc = (s == 1);
            st_scl = (s == 2);
            strap_v = STRAP_TBL[s];
            repeat (20) @(negedge clk);
            chk_flag(sda_oe | wr_valid | busy, 1'b0);
            chk_val({8'h00, rd_addr}, 16'h0000);
            rst_b = 1'b1;
            repeat (4) @(negedge clk);
            u_host.start_cond();
            u_host.put_byte(addr_byte(strap_v, 1'b0) ^ (s[0] ? 8'h02 : 8'h80),
                            ack);
            chk_flag(ack, 1'b0);
            u_host.stop_cond();
            p = rnd8();
            open_write(p);
            for (int i = 0; i < 2 + s; i++) begin
                send_data(p + 8'(i), ack);
                chk_flag(ack, 1'b1);
            end
            u_host.stop_cond();
            wait_drain();
            rd_burst(p, 2 + s, 1'b1);
        end
        // stalled bank: fill until a byte is refused, wrap the pointer
        ready_mode = 0;
        p = 8'hF8;
        open_write(p);
        n = 0;
        ack = 1'b1;
        while (ack && n < ITP_FIFO_DEPTH + 4) begin
            send_data(p + 8'(n), ack);
            n += ack;
        end
        u_host.stop_cond();
        chk_flag(n >= ITP_FIFO_DEPTH && n <= ITP_FIFO_DEPTH + 1, 1'b1);
        ready_mode = 2;
        wait_drain();
        rd_burst(p + 8'(n), 2, 1'b0);
        chk_val(16'(u_host.glitch_cnt), 16'h0000);
        chk_val(16'(exp_q.size()), 16'h0000);
        report_and_stop();
    end
endmodule : tb
